// >>> design/hdmi_tx_event_consts.vh
// Register offsets, field positions, reset values and timing counts of the event block
`ifndef HDMI_TX_EVENT_CONSTS_VH
`define HDMI_TX_EVENT_CONSTS_VH

// Register byte offsets on the bus
`define REG_STATUS       8'h00
`define REG_MASK         8'h04
`define REG_LEVELS       8'h08
`define REG_CONTROL      8'h0C
`define REG_KEY_DATA     8'h10
`define REG_KEY_STATUS   8'h14
`define REG_CONFIG       8'h18

// Event bit positions in status and mask
`define EV_CONNECT       0
`define EV_DISCONNECT    1
`define EV_TOGGLE        2
`define EV_LINK_READY    3
`define EV_VSYNC         4
`define EV_BRIDGE_UNLOCK 5
`define EV_HDCP14        6
`define EV_HDCP14_TIMER  7
`define EV_HDCP22_TIMER  8
`define EV_COUNT         9

// Levels register bit positions
`define LV_HOTPLUG       0
`define LV_LINK_STATUS   1
`define LV_CONNECTED     2
`define LV_ENCRYPTED     3
`define LV_LINK_EDGE     4

// Control register bit positions
`define CT_ENCRYPT_EN    0
`define CT_KEYS_DONE     1

// Key status bit positions
`define KS_LOCKED        0
`define KS_BYTE_VALID    1

// Reset values
`define MASK_RESET       9'h000
`define CONTROL_RESET    2'h0

// Clock and hot-plug timing, times in microseconds
`define CLK_MHZ          125
`define T_CONNECT_US     10000
`define T_DISCONNECT_US  100000
`define T_TOGGLE_MIN_US  50000
`define T_TOGGLE_MAX_US  99000
`define N_CONNECT        (`T_CONNECT_US * `CLK_MHZ)
`define N_DISCONNECT     (`T_DISCONNECT_US * `CLK_MHZ)
`define N_TOGGLE_MIN     (`T_TOGGLE_MIN_US * `CLK_MHZ)
`define N_TOGGLE_MAX     (`T_TOGGLE_MAX_US * `CLK_MHZ)

`endif

// >>> design/hdmi_tx_event_sources.v
// Event sources, sticky status and interrupt of the transmitter event block
//
// Summary of operation
// - Connect after disconnect plus 10 ms high
// - Disconnect after 100 ms low
// - Pulse 50 to 99 ms gives toggle
// - Link status bit tracks stable link clock
// - Link status edges raise link-ready event
// - Vsync rising edge raises event
// - Bridge lock loss raises unlocked event
// - HDCP 1.4 interrupts only when configured
// - Key readout locked after key init success
// - Encryption status shows cipher state
// - HDCP 2.2 timer only when configured
`timescale 1ns/1ps
`include "hdmi_tx_event_consts.vh"

module hdmi_tx_event_sources #(
    parameter HDCP14_EN  = 1,                      // HDCP 1.4 included in hardware
    parameter HDCP22_EN  = 1,                      // HDCP 2.2 included in hardware
    parameter N_CONNECT    = `N_CONNECT,           // Cycles of high before connect
    parameter N_DISCONNECT = `N_DISCONNECT,        // Cycles of low before disconnect
    parameter N_TOGGLE_MIN = `N_TOGGLE_MIN,        // Shortest toggle pulse, cycles
    parameter N_TOGGLE_MAX = `N_TOGGLE_MAX         // Longest toggle pulse, cycles
) (
    input  wire        core_clk,                   // Block clock, 125 MHz
    input  wire        rst,                        // Synchronous reset, active high
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    // Event sources
    input  wire        hotplug,                    // Hot-plug level from the sink
    input  wire        link_clk_stable,            // PHY reports stable link clock
    input  wire        vsync,                      // Video interface vertical sync
    input  wire        bridge_locked,              // Stream-to-video bridge lock
    input  wire        hdcp14_irq,                 // HDCP 1.4 engine event pulse
    input  wire        hdcp14_timer_irq,           // HDCP 1.4 timer event pulse
    input  wire        hdcp22_timer_irq,           // HDCP 2.2 timer event pulse
    input  wire        cipher_active,              // Cipher currently encrypting
    input  wire        authenticated,              // Authentication has succeeded
    // Outputs
    output reg         irq,                        // Level interrupt
    output reg         encrypt_en,                 // Encryption request to cipher
    output reg         key_byte_valid,             // Key byte strobe to key store
    output reg  [7:0]  key_byte                    // Key byte, most significant first
);

    ////////////////////////////////////////////////////////////////////////////////////
    // Counters wide enough for the 100 ms window at 125 MHz
    localparam CW = 24;

    // Toggle window ends, cut to counter width on purpose
    localparam [31:0]   TLO_W  = N_TOGGLE_MIN - 1;
    localparam [31:0]   THI_W  = N_TOGGLE_MAX - 1;
    localparam [CW-1:0] TOG_LO = TLO_W[CW-1:0];
    localparam [CW-1:0] TOG_HI = THI_W[CW-1:0];

    // Hot-plug qualifier states
    // Levels only; events are strobes
    // decided in the same block below
    localparam [1:0] HP_WAIT_LOW  = 2'h0;          // Waiting for a disconnect
    localparam [1:0] HP_LOW       = 2'h1;          // Line low, counting
    localparam [1:0] HP_DISC_HIGH = 2'h2;          // Disconnected, line high, counting
    localparam [1:0] HP_CONN      = 2'h3;          // Connected, line high

    reg [1:0]         hp_state_ff;                 // Qualifier state
    reg [1:0]         nxt_hp_state;
    reg [CW-1:0]      hp_cnt_ff;                   // Cycles at current level
    reg [CW-1:0]      nxt_hp_cnt;
    reg               hp_prev_ff;                  // Previous hot-plug level
    reg               disc_seen_ff;                // Disconnect has happened
    reg               nxt_disc_seen;
    reg               connected_ff;                // Cable considered connected
    reg               nxt_connected;
    reg               ev_connect;                  // Connect event this cycle
    reg               ev_disconnect;               // Disconnect event this cycle
    reg               ev_toggle;                   // Toggle event this cycle

    reg               link_ff;                     // Link status bit
    reg               link_edge_ff;                // Last link edge: 1 up, 0 down
    reg               vsync_prev_ff;               // Previous vsync level
    reg               lock_prev_ff;                // Previous bridge lock level
    reg [`EV_COUNT-1:0] status_ff;                 // Sticky pending flags
    reg [`EV_COUNT-1:0] mask_ff;                   // Enable per flag
    reg               keys_done_ff;                // Key store initialised
    reg               key_lock_ff;                 // Key readout forbidden
    wire [`EV_COUNT-1:0] events;                   // One-cycle event vector
    wire [`EV_COUNT-1:0] cfg_mask;                 // Flags present in hardware

    // Saturating count step, used by the hot-plug counter
    // Saturating stops a parked line
    // from wrapping into a short pulse
    function [CW-1:0] inc_sat;
        input [CW-1:0] v;
        begin
            inc_sat = (&v) ? v : v + 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////
    // Hot-plug qualifier: counts cycles at each level, decides on level changes and on count limits
    // Count restarts at each change: a
    // level held N+1 cycles meets N here.
    // Disconnect fires once; connect
    // re-arms it through disc_seen_ff
    always @* begin
        nxt_hp_state  = hp_state_ff;
        nxt_hp_cnt    = (hotplug != hp_prev_ff) ? {CW{1'b0}} : inc_sat(hp_cnt_ff);
        nxt_disc_seen = disc_seen_ff;
        nxt_connected = connected_ff;
        ev_connect    = 1'b0;
        ev_disconnect = 1'b0;
        ev_toggle     = 1'b0;
        case (hp_state_ff)
            HP_WAIT_LOW, HP_CONN: begin
                // Line dropped: start timing the low phase
                if (!hotplug) begin
                    nxt_hp_state = HP_LOW;
                end
            end
            HP_LOW: begin
                if (hotplug) begin
                    // toggle window
                    // A pulse shorter than 100 ms never reaches disconnect
                    if (!disc_seen_ff && hp_cnt_ff >= TOG_LO &&
                        hp_cnt_ff <= TOG_HI) begin
                        ev_toggle = 1'b1;
                    end
                    nxt_hp_state = disc_seen_ff ? HP_DISC_HIGH :
                                   (connected_ff ? HP_CONN : HP_WAIT_LOW);
                end else if (!disc_seen_ff && hp_cnt_ff == N_DISCONNECT[CW-1:0]) begin
                    ev_disconnect = 1'b1;
                    nxt_disc_seen = 1'b1;
                    nxt_connected = 1'b0;
                end
            end
            HP_DISC_HIGH: begin
                // Dropped before connect: new low
                if (!hotplug) begin
                    nxt_hp_state = HP_LOW;
                end else if (hp_cnt_ff == N_CONNECT[CW-1:0]) begin
                    // high beyond 10 ms after a disconnect
                    ev_connect    = 1'b1;
                    nxt_disc_seen = 1'b0;
                    nxt_connected = 1'b1;
                    nxt_hp_state  = HP_CONN;
                end
            end
            // Unreachable; safe landing
            default: begin
                nxt_hp_state = HP_WAIT_LOW;
            end
        endcase
    end

    // Hot-plug qualifier registers; a cable present at reset is not yet connected
    // No disconnect at reset: a cable
    // needs an unplug before connect
    always @(posedge core_clk) begin
        if (rst) begin
            hp_state_ff  <= HP_WAIT_LOW;
            hp_cnt_ff    <= {CW{1'b0}};
            hp_prev_ff   <= 1'b0;
            disc_seen_ff <= 1'b0;
            connected_ff <= 1'b0;
        end else begin
            hp_state_ff  <= nxt_hp_state;
            hp_cnt_ff    <= nxt_hp_cnt;
            hp_prev_ff   <= hotplug;
            disc_seen_ff <= nxt_disc_seen;
            connected_ff <= nxt_connected;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Link status, vsync and bridge lock edge tracking
    // Levels are taken as synchronous;
    // the source registers them first.
    // Prev flops reset low, so an idle
    // pin gives no false edge
    always @(posedge core_clk) begin
        if (rst) begin
            link_ff       <= 1'b0;
            link_edge_ff  <= 1'b0;
            vsync_prev_ff <= 1'b0;
            lock_prev_ff  <= 1'b0;
        end else begin
            // status bit follows link clock stability
            link_ff       <= link_clk_stable;
            // Keep direction of last change
            if (link_ff != link_clk_stable) begin
                link_edge_ff <= link_clk_stable;
            end
            vsync_prev_ff <= vsync;
            lock_prev_ff  <= bridge_locked;
        end
    end

    // Absent flags forced to 0 here
    // HDCP 1.4 flags exist only when configured
    // HDCP 2.2 timer flag exists only when configured
    assign cfg_mask = {HDCP22_EN != 0, HDCP14_EN != 0, HDCP14_EN != 0, 6'h3F};

    // Event vector, one cycle per occurrence
    // HDCP strobes held high set the
    // flag again every cycle
    assign events[`EV_CONNECT]       = ev_connect;
    assign events[`EV_DISCONNECT]    = ev_disconnect;
    assign events[`EV_TOGGLE]        = ev_toggle;
    // any change of the link status bit
    assign events[`EV_LINK_READY]    = link_ff != link_clk_stable;
    assign events[`EV_VSYNC]         = vsync & ~vsync_prev_ff;
    assign events[`EV_BRIDGE_UNLOCK] = lock_prev_ff & ~bridge_locked;
    assign events[`EV_HDCP14]        = hdcp14_irq;
    assign events[`EV_HDCP14_TIMER]  = hdcp14_timer_irq;
    assign events[`EV_HDCP22_TIMER]  = hdcp22_timer_irq;

    ////////////////////////////////////////////////////////////////////////////////////
    // Bus access decode; single-cycle answer, ack never held two cycles
    // Lane 0 qualifies each write;
    // lane 1 adds bit 8 of flags/mask.
    // Ack term stops a double take
    wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire        bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    wire        bus_hit = (wb_adr_i == `REG_STATUS)   || (wb_adr_i == `REG_MASK)   ||
                          (wb_adr_i == `REG_LEVELS)   || (wb_adr_i == `REG_CONTROL) ||
                          (wb_adr_i == `REG_KEY_DATA) || (wb_adr_i == `REG_KEY_STATUS) ||
                          (wb_adr_i == `REG_CONFIG);
    wire        wr_status = bus_wr & (wb_adr_i == `REG_STATUS);
    wire [`EV_COUNT-1:0] clr_bits = wr_status ? {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0]}
                                              : {`EV_COUNT{1'b0}};

    // Sticky flags and mask
    // Mask gates irq only; flags set
    always @(posedge core_clk) begin
        if (rst) begin
            status_ff <= {`EV_COUNT{1'b0}};
            mask_ff   <= `MASK_RESET;
        end else begin
            // write-one clear; a new event wins over the clear
            status_ff <= ((status_ff & ~clr_bits) | events) & cfg_mask;
            if (bus_wr && wb_adr_i == `REG_MASK) begin
                // Bit 8 needs lane 1 selected
                mask_ff <= {wb_sel_i[1] ? wb_dat_i[8] : mask_ff[8], wb_dat_i[7:0]} & cfg_mask;
            end
        end
    end

    // Interrupt level, registered
    // Uses next status: irq rises with
    // the flag, a mask change one later
    always @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            // high while an enabled flag is pending
            irq <= |(((status_ff & ~clr_bits) | events) & cfg_mask & mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Control, key path and key lock
    // Encryption drops the edge after auth,
    // so it runs one cycle unauthenticated at most.
    // Keys done is sticky; the lock
    // follows one edge later
    always @(posedge core_clk) begin
        if (rst) begin
            encrypt_en     <= 1'b0;
            keys_done_ff   <= 1'b0;
            key_lock_ff    <= 1'b0;
            key_byte_valid <= 1'b0;
            key_byte       <= 8'h00;
        end else begin
            key_byte_valid <= 1'b0;
            if (bus_wr && wb_adr_i == `REG_CONTROL) begin
                encrypt_en   <= wb_dat_i[`CT_ENCRYPT_EN] & authenticated;
                keys_done_ff <= keys_done_ff | wb_dat_i[`CT_KEYS_DONE];
            end else if (!authenticated) begin
                // Losing authentication also drops encryption
                encrypt_en <= 1'b0;
            end
            // No byte count; order is the loader's
            // software feeds octets MSB first, passed in order
            if (bus_wr && wb_adr_i == `REG_KEY_DATA && !key_lock_ff) begin
                key_byte       <= wb_dat_i[7:0];
                key_byte_valid <= 1'b1;
            end
            // Reset stands in for reprogramming
            // lock set once key init succeeds; only reset clears it
            if (keys_done_ff) begin
                key_lock_ff <= 1'b1;
            end
        end
    end

    // Read data mux and answer; unmapped addresses answer with err
    // Read data stands in ack cycle.
    // Reads have no side effects.
    // Key data reads 0 once locked
    always @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req & bus_hit;
            wb_err_o <= bus_req & ~bus_hit;
            wb_dat_o <= 32'h00000000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `REG_STATUS:     wb_dat_o <= {23'h000000, status_ff};
                    `REG_MASK:       wb_dat_o <= {23'h000000, mask_ff};
                    // live cipher state, may change per frame
                    `REG_LEVELS:     wb_dat_o <= {27'h0000000, link_edge_ff, cipher_active,
                                                  connected_ff, link_ff, hotplug};
                    `REG_CONTROL:    wb_dat_o <= {30'h00000000, keys_done_ff, encrypt_en};
                    `REG_KEY_DATA:   wb_dat_o <= key_lock_ff ? 32'h00000000
                                                             : {24'h000000, key_byte};
                    `REG_KEY_STATUS: wb_dat_o <= {30'h00000000, key_byte_valid, key_lock_ff};
                    `REG_CONFIG:     wb_dat_o <= {30'h00000000, HDCP22_EN != 0,
                                                  HDCP14_EN != 0};
                    default:         wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // hdmi_tx_event_sources

// >>> dv/hdmi_tx_event_properties.sv
// Port assertions for the event block
`timescale 1ns/1ps
`include "hdmi_tx_event_consts.vh"
module hdmi_tx_event_properties (
    input wire        core_clk,
    input wire        rst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire        authenticated,
    input wire        irq,
    input wire        encrypt_en,
    input wire        key_byte_valid,
    input wire [7:0]  key_byte
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    wire       req_w = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; // Request taken
    wire       wrq_w = wb_cyc_i && wb_stb_i && wb_we_i;  // Write on the bus
    wire       wr_w  = req_w && wb_we_i && wb_sel_i[0];  // Write taken
    wire       kw_w  = wr_w && wb_adr_i == `REG_KEY_DATA; // Key byte write
    reg        lock_ff;                                 // Shadow of key lock
    reg  [7:0] byte_ff;                                 // Last key byte written
    // Shadow lock; only reset clears it, as in the block
    always @(posedge core_clk) begin
        if (rst) begin
            lock_ff <= 1'b0;
            byte_ff <= 8'h00;
        end else begin
            if (wr_w && wb_adr_i == `REG_CONTROL && wb_dat_i[1]) begin
                lock_ff <= 1'b1;
            end
            if (kw_w) begin
                byte_ff <= wb_dat_i[7:0];
            end
        end
    end
    ////////////////////////////////////////
    bus_answer_a: assert property (req_w |=> wb_ack_o ^ wb_err_o)
        else $error("bus request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    err_unmapped_a: assert property (req_w && wb_adr_i > `REG_CONFIG |=> wb_err_o)
        else $error("unmapped address accepted");
    irq_clear_a: assert property ($fell(irq) |-> $past(wrq_w) || $past(wrq_w, 2))
        else $error("irq fell without a write");
    encrypt_auth_a: assert property ($rose(encrypt_en) |-> $past(authenticated))
        else $error("encryption without authentication");
    encrypt_drop_a: assert property (!authenticated |=> !encrypt_en)
        else $error("encryption kept after auth loss");
    key_pulse_a: assert property (kw_w && !lock_ff |-> ##[1:2] key_byte_valid)
        else $error("key byte not passed on");
    key_data_a: assert property (key_byte_valid |-> key_byte == byte_ff)
        else $error("key byte differs from written");
    key_locked_a: assert property ($past(lock_ff, 2) |-> !key_byte_valid)
        else $error("key byte passed after lock");
    key_seen_c: cover property (key_byte_valid);
    encrypt_on_c: cover property ($rose(encrypt_en));
    refuse_c: cover property (wb_err_o);
endmodule // hdmi_tx_event_properties
bind hdmi_tx_event_sources hdmi_tx_event_properties u_props (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .authenticated(authenticated), .irq(irq),
    .encrypt_en(encrypt_en), .key_byte_valid(key_byte_valid), .key_byte(key_byte)
);

// >>> dv/hotplug_sink_model.sv
// Sink hot-plug line and PHY link clock status
`timescale 1ns/1ps
module hotplug_sink_model (
    input  wire core_clk,        // Block clock
    output reg  hotplug,         // Hot-plug level, high when asserted
    output reg  link_clk_stable  // Link clock regenerated and stable
);
    // Cable out and PHY idle at start
    initial begin
        hotplug = 1'b0;
        link_clk_stable = 1'b0;
    end
    // Hold the line at a level; long holds model a slow sink
    task hold(input lvl, input integer n);
        begin
            hotplug <= lvl;
            repeat (n) @(posedge core_clk);
        end
    endtask
    // Low pulse of width w, then the line returns high
    task pulse_low(input integer w);
        begin
            hold(1'b0, w);
            hold(1'b1, 30);
        end
    endtask
    task link(input lvl);
        link_clk_stable <= lvl;
    endtask
endmodule // hotplug_sink_model

// >>> dv/testbench.sv
// Self-checking bench for the event block
`timescale 1ns/1ps
`include "hdmi_tx_event_consts.vh"
module testbench;
    reg         core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i; // Clock, reset, strobes
    reg  [7:0]  wb_adr_i;                       // Bus address
    reg  [3:0]  wb_sel_i;                       // Byte lanes
    reg  [31:0] wb_dat_i;                       // Write data
    reg  [4:0]  src;                            // Event sources
    reg         cipher_active, authenticated;   // Cipher and auth levels
    reg  [7:0]  lfsr;                           // Random byte state
    wire [31:0] wb_dat_o;                       // Read data
    wire        wb_ack_o, wb_err_o, irq, encrypt_en;
    wire        key_byte_valid, hotplug, link_clk_stable;
    wire [7:0]  key_byte;                       // Key byte out
    reg  [33:0] exp_q[$];                       // Notes: err, compare, data
    reg  [33:0] note;                           // Note being checked
    integer     fail_count, checks, cyc_n, i;   // Counters
    integer     pw [0:3] = '{49, 50, 99, 150};  // Low pulse widths
    integer     pe [0:3] = '{0, 4, 4, 3};       // Status after each pulse
    hdmi_tx_event_sources #(.N_CONNECT(20), .N_DISCONNECT(100), .N_TOGGLE_MIN(50),
                            .N_TOGGLE_MAX(99)) u_dut (
        .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .hotplug(hotplug),
        .link_clk_stable(link_clk_stable), .vsync(src[0]), .bridge_locked(~src[1]),
        .hdcp14_irq(src[2]), .hdcp14_timer_irq(src[3]), .hdcp22_timer_irq(src[4]),
        .cipher_active(cipher_active), .authenticated(authenticated), .irq(irq),
        .encrypt_en(encrypt_en), .key_byte_valid(key_byte_valid), .key_byte(key_byte)
    );
    hotplug_sink_model u_sink (.core_clk(core_clk), .hotplug(hotplug),
                               .link_clk_stable(link_clk_stable));
    ////////////////////////////////////////
    function [7:0] lfsr_next(input [7:0] v);
        lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] s);
        begin
            checks = checks + 1;
            if (s !== e) begin
                fail_count = fail_count + 1;
                $display("[ERR] %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    // One classic cycle; held until the answer is sampled
    task wb(input w, input [7:0] a, input [31:0] d, input [33:0] n);
        begin
            exp_q.push_back(n);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i  <= w;
            wb_sel_i <= 4'hF;
            wb_adr_i <= a;
            wb_dat_i <= d;
            do @(posedge core_clk); while (!(wb_ack_o || wb_err_o));
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        wb(1'b1, a, d, 34'h0);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        wb(1'b0, a, 32'h0, {2'b01, e});
    endtask
    task tick(input integer n);
        repeat (n) @(posedge core_clk);
    endtask
    task done(input string nm);
        $display("test %s finished", nm);
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Monitor: oldest note against each answer
    always @(posedge core_clk) begin
        if (!rst && (wb_ack_o || wb_err_o)) begin
            note = exp_q.pop_front();
            chk("bus error", {31'h0, note[33]}, {31'h0, wb_err_o});
            if (note[32]) chk("read data", note[31:0], wb_dat_o);
        end
    end
    // Cut a hang short
    always @(posedge core_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 3000) begin
            fail_count = fail_count + 1;
            summarize;
        end
    end
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, src} = {8'h00, 4'hF, 32'h0, 5'h00};
        {cipher_active, authenticated, lfsr} = {2'b00, 8'h4F};
        {fail_count, checks, cyc_n} = 0;
        tick(3);
        rst <= 1'b0;
        tick(1);
        rd(`REG_MASK, 32'h0);
        rd(`REG_CONFIG, 32'h3);
        wb(1'b0, 8'h1C, 32'h0, {2'b10, 32'h0});
        wr(`REG_MASK, 32'h1FF);
        u_sink.hold(1'b0, 110);
        rd(`REG_STATUS, 32'h2);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`REG_STATUS, 32'h1FF);
        u_sink.hold(1'b1, 30);
        rd(`REG_STATUS, 32'h1);
        wr(`REG_STATUS, 32'h1FF);
        for (i = 0; i < 4; i = i + 1) begin
            u_sink.pulse_low(pw[i]);
            rd(`REG_STATUS, pe[i]);
            wr(`REG_STATUS, 32'h1FF);
        end
        tick(2);
        chk("irq", 32'h0, {31'h0, irq});
        done("hotplug");
        for (i = 1; i >= 0; i = i - 1) begin
            u_sink.link(i[0]);
            tick(4);
            rd(`REG_STATUS, 32'h8);
            rd(`REG_LEVELS, 32'h5 | (i * 32'h12));
            wr(`REG_STATUS, 32'h1FF);
        end
        done("link");
        for (i = 0; i < 6; i = i + 1) begin
            if (i == 5) wr(`REG_MASK, 32'h0EF);
            src <= 5'h01 << (i % 5);
            tick(1);
            src <= 5'h00;
            tick(3);
            chk("irq", (i < 5), {31'h0, irq});
            rd(`REG_STATUS, 32'h10 << (i % 5));
            if (i < 5) wr(`REG_STATUS, 32'h1FF);
        end
        wr(`REG_MASK, 32'h1FF);
        tick(2);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        wr(`REG_STATUS, 32'h10);
        tick(2);
        chk("cleared irq", 32'h0, {31'h0, irq});
        done("events");
        wr(`REG_CONTROL, 32'h1);
        rd(`REG_CONTROL, 32'h0);
        u_sink.link(1'b1);
        authenticated <= 1'b1;
        cipher_active <= 1'b1;
        tick(1);
        wr(`REG_CONTROL, 32'h1);
        rd(`REG_CONTROL, 32'h1);
        rd(`REG_LEVELS, 32'h1F);
        authenticated <= 1'b0;
        tick(3);
        chk("encrypt", 32'h0, {31'h0, encrypt_en});
        done("encrypt");
        for (i = 0; i < 3; i = i + 1) begin
            lfsr = lfsr_next(lfsr);
            wr(`REG_KEY_DATA, {24'h0, lfsr});
        end
        rd(`REG_KEY_DATA, {24'h0, lfsr});
        wr(`REG_CONTROL, 32'h2);
        rd(`REG_KEY_STATUS, 32'h1);
        wr(`REG_KEY_DATA, 32'hA5);
        rd(`REG_KEY_DATA, 32'h0);
        done("keys");
        summarize;
    end
endmodule // testbench
